// ### src/rfs_regs.svh
`ifndef RFS_REGS_SVH
`define RFS_REGS_SVH
`define RFS_IDX_TXCTL      8'h05
`define RFS_IDX_RXSTAT     8'h06
`define RFS_IDX_ED         8'h07
`define RFS_IDX_NONE       8'hFF
`define RFS_TXCTL_AUTO_BIT 7
`define RFS_RXSTAT_OK_BIT  7
`define RFS_REG_RST        8'h00
`define RFS_RSSI_MAX       5'h1C
`define RFS_ED_MAX         8'h54
`define RFS_MIN_FCS_LEN    7'h02
`define RFS_CLK_MHZ        100
`define RFS_ED_WIN_US      128
`define RFS_ED_DONE_US     140
`define RFS_RSSI_US        2
`define RFS_ED_SAMPLES     (`RFS_ED_WIN_US / `RFS_RSSI_US)
`define RFS_ED_SHIFT       6
`endif

// ### src/rfs_pkg.sv
package rfs_pkg;
   typedef logic [7:0] rfs_byte_type;
   typedef logic [4:0] rfs_rssi_type;
   typedef enum logic {
      RFS_ED_IDLE,
      RFS_ED_RUN
   } rfs_ed_state_type;
endpackage

// ### src/rfs_meas_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rfs_meas_if;
   logic                 start;
   logic                 sample_stb;
   rfs_pkg::rfs_rssi_type sample;
   logic                 busy;
   logic                 done;
   rfs_pkg::rfs_byte_type result;
   modport core (output start, output sample_stb, output sample,
                 input busy, input done, input result);
   modport ed   (input start, input sample_stb, input sample,
                 output busy, output done, output result);
endinterface
`default_nettype wire

// ### src/rfs_fcs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rfs_fcs_chk (
   input  wire logic             sys_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             clear_i,
   input  wire logic             byte_vld_i,
   input  wire rfs_pkg::rfs_byte_type byte_i,
   output logic                  fcs_ok_o
);
   import rfs_pkg::*;
   logic [15:0] crc_r;

   // reflected polynomial, zero start; residue over data plus fcs is zero
   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input rfs_byte_type b);
      logic [15:0] v;
      v = c;
      for (int i = 0; i < 8; i++) begin
         v = v[0] ^ b[i] ? ((v >> 1) ^ 16'h8408) : (v >> 1);
      end
      return v;
   endfunction

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         crc_r    <= 16'h0000;
         fcs_ok_o <= 1'b0;
      end else if (clear_i) begin
         crc_r    <= 16'h0000;
         fcs_ok_o <= 1'b0;
      end else if (byte_vld_i) begin
         crc_r    <= crc_step(crc_r, byte_i);
         fcs_ok_o <= crc_step(crc_r, byte_i) == 16'h0000;
      end
   end
endmodule
`default_nettype wire

// ### src/rfs_ed_avg.sv
`timescale 1ns/1ps
`default_nettype none
`include "rfs_regs.svh"
module rfs_ed_avg #(
   parameter int DONE_CYC = `RFS_ED_DONE_US * `RFS_CLK_MHZ
) (
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   rfs_meas_if.ed    meas
);
   import rfs_pkg::*;
   localparam logic [15:0] DONE_M2 = 16'(DONE_CYC - 2);
   localparam logic [6:0]  NSAMP   = 7'(`RFS_ED_SAMPLES);
   rfs_ed_state_type st_r;
   logic [15:0]      tmr_r;
   logic [6:0]       cnt_r;
   logic [10:0]      acc_r;
   logic [12:0]      prod;
   logic [6:0]       avg;
   logic             fin;
   logic             done_r;
   rfs_byte_type     result_r;

   assign fin  = (st_r == RFS_ED_RUN) && !meas.start && (tmr_r == DONE_M2);
   assign prod = {2'b00, acc_r} + {1'b0, acc_r, 1'b0};
   assign avg  = prod[12:`RFS_ED_SHIFT];

   // a new start restarts the window; the old result stays meanwhile
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r  <= RFS_ED_IDLE;
         tmr_r <= 16'h0000;
      end else if (meas.start) begin
         st_r  <= RFS_ED_RUN;
         tmr_r <= 16'h0000;
      end else begin
         case (st_r)
            RFS_ED_RUN: begin
               if (fin) st_r <= RFS_ED_IDLE;
               else tmr_r <= tmr_r + 16'h0001;
            end
            default: st_r <= RFS_ED_IDLE;
         endcase
      end
   end

   // eight symbols of 2 us samples, then hold the sum
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_r <= 11'h000;
         cnt_r <= 7'h00;
      end else if (meas.start) begin
         acc_r <= 11'h000;
         cnt_r <= 7'h00;
      end else if (st_r == RFS_ED_RUN && meas.sample_stb &&
                   cnt_r < NSAMP) begin
         acc_r <= acc_r + {6'h00, meas.sample};
         cnt_r <= cnt_r + 7'h01;
      end
   end

   // sum*3/64 turns 3 dB steps into 1 dB steps, at most 84
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_r   <= 1'b0;
         result_r <= `RFS_REG_RST;
      end else begin
         done_r <= fin;
         if (fin) begin
            result_r <= ({1'b0, avg} > `RFS_ED_MAX) ? `RFS_ED_MAX
                                                    : {1'b0, avg};
         end
      end
   end

   assign meas.busy   = (st_r == RFS_ED_RUN);
   assign meas.done   = done_r;
   assign meas.result = result_r;
endmodule
`default_nettype wire

// ### src/rfs_top.sv
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "rfs_regs.svh"
module rfs_top #(
   parameter int ED_DONE_CYC = `RFS_ED_DONE_US * `RFS_CLK_MHZ,
   parameter int RSSI_CYC    = `RFS_RSSI_US * `RFS_CLK_MHZ
) (
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_n_i,
   // ahb-lite slave
   input  wire logic                  hsel_i,
   input  wire logic [31:0]           haddr_i,
   input  wire logic [1:0]            htrans_i,
   input  wire logic                  hwrite_i,
   input  wire logic [2:0]            hsize_i,
   input  wire logic [31:0]           hwdata_i,
   input  wire logic                  hready_i,
   output logic                       hreadyout_o,
   output logic                       hresp_o,
   output logic [31:0]                hrdata_o,
   // radio side
   input  wire logic                  rx_state_i,
   input  wire logic                  ext_mode_i,
   input  wire logic                  auto_ack_receive_i,
   input  wire logic                  auto_retry_transmit_i,
   input  wire logic                  sfd_detect_i,
   input  wire logic                  rx_byte_vld_i,
   input  wire rfs_pkg::rfs_byte_type rx_byte_i,
   input  wire logic                  rx_frame_end_i,
   input  wire logic [6:0]            rx_len_i,
   input  wire rfs_pkg::rfs_rssi_type rssi_level_i,
   output logic                       frame_start_irq_o,
   output logic                       frame_done_irq_o,
   output logic                       frame_discard_o,
   output logic                       ack_accept_o,
   output logic                       ack_reject_o,
   output logic                       tx_auto_fcs_o,
   output logic [3:0]                 tx_power_setting_o
);
   import rfs_pkg::*;

   localparam logic [15:0] RSSI_M1 = 16'(RSSI_CYC - 1);
   localparam logic [15:0] ED_M1   = 16'(ED_DONE_CYC - 1);

   rfs_meas_if meas ();

   ////////////////////////////////////////////////////////////////////////
   // bus slave

   logic         wr_r;
   logic [7:0]   wr_idx_r;
   logic         take;
   logic [7:0]   a_idx;
   logic         wr_txctl;
   logic         wr_ed;
   logic [3:0]   pwr_r;
   logic         auto_r;
   logic         ok_r;
   rfs_rssi_type rssi_r;
   rfs_byte_type ed_r;

   // word index from a byte address; anything above the first 1 KiB or not word aligned is NONE
   function automatic logic [7:0] reg_index(input logic [31:0] a);
      if (a[31:10] != 22'h000000 || a[1:0] != 2'b00) return `RFS_IDX_NONE;
      return a[9:2];
   endfunction

   assign take        = hsel_i && htrans_i[1] && hready_i;
   assign a_idx       = reg_index(haddr_i);
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_r     <= 1'b0;
         wr_idx_r <= `RFS_IDX_NONE;
      end else if (hready_i) begin
         wr_r     <= take && hwrite_i && hsize_i == 3'h2;
         wr_idx_r <= a_idx;
      end
   end

   assign wr_txctl = wr_r && wr_idx_r == `RFS_IDX_TXCTL;
   assign wr_ed    = wr_r && wr_idx_r == `RFS_IDX_ED;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         auto_r <= 1'b0;
         pwr_r  <= 4'h0;
      end else if (wr_txctl) begin
         auto_r <= hwdata_i[`RFS_TXCTL_AUTO_BIT];
         pwr_r  <= hwdata_i[3:0];
      end
   end

   assign tx_auto_fcs_o      = auto_r;
   assign tx_power_setting_o = pwr_r;

   // read data registered in the address phase: zero wait states,
   // but a read right behind a write to the same word sees the old value
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hrdata_o <= 32'h00000000;
      end else if (take && !hwrite_i) begin
         case (a_idx)
            `RFS_IDX_TXCTL:  hrdata_o <= {24'h000000, auto_r, 3'h0, pwr_r};
            `RFS_IDX_RXSTAT: hrdata_o <= {24'h000000, ok_r, 2'h0, rssi_r};
            `RFS_IDX_ED:     hrdata_o <= rx_state_i ? {24'h000000, ed_r}
                                                    : 32'h00000000;
            default:         hrdata_o <= 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // frame checksum

   logic fcs_ok;
   logic chk_ok;

   rfs_fcs_chk u_fcs (
      .sys_clk_i  (sys_clk_i),
      .rst_n_i    (rst_n_i),
      .clear_i    (sfd_detect_i),
      .byte_vld_i (rx_byte_vld_i),
      .byte_i     (rx_byte_i),
      .fcs_ok_o   (fcs_ok)
   );

   // too short to carry a checksum counts as not valid
   assign chk_ok = fcs_ok && rx_len_i >= `RFS_MIN_FCS_LEN;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frame_done_irq_o <= 1'b0;
         frame_discard_o  <= 1'b0;
         ack_accept_o     <= 1'b0;
         ack_reject_o     <= 1'b0;
      end else begin
         frame_done_irq_o <= rx_frame_end_i && !auto_retry_transmit_i &&
                             (chk_ok || !auto_ack_receive_i);
         frame_discard_o  <= rx_frame_end_i && !auto_retry_transmit_i &&
                             auto_ack_receive_i && !chk_ok;
         ack_accept_o     <= rx_frame_end_i && auto_retry_transmit_i &&
                             chk_ok;
         ack_reject_o     <= rx_frame_end_i && auto_retry_transmit_i &&
                             !chk_ok;
      end
   end

   // flag only moves together with the frame-done interrupt
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ok_r <= 1'b0;
      end else if (rx_frame_end_i && !auto_retry_transmit_i &&
                   (chk_ok || !auto_ack_receive_i)) begin
         ok_r <= chk_ok;
      end
   end

   // extended mode signals frames by frame-done only
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frame_start_irq_o <= 1'b0;
      end else begin
         frame_start_irq_o <= sfd_detect_i && rx_state_i &&
                              !ext_mode_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // signal strength

   logic [15:0] rssi_tmr_r;
   logic        rssi_stb;

   assign rssi_stb = rx_state_i && rssi_tmr_r == RSSI_M1;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rssi_tmr_r <= 16'h0000;
      end else if (!rx_state_i || rssi_stb) begin
         rssi_tmr_r <= 16'h0000;
      end else begin
         rssi_tmr_r <= rssi_tmr_r + 16'h0001;
      end
   end

   // raw power only, clamped to the top code of 28
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rssi_r <= 5'h00;
      end else if (!rx_state_i) begin
         rssi_r <= 5'h00;
      end else if (rssi_stb) begin
         rssi_r <= (rssi_level_i > `RFS_RSSI_MAX) ? `RFS_RSSI_MAX
                                                  : rssi_level_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // energy detect

   // manual writes outside receive states are ignored; a delimiter
   // also starts a run
   assign meas.start      = rx_state_i && (wr_ed || sfd_detect_i);
   assign meas.sample_stb = rssi_stb;
   assign meas.sample     = rssi_r;

   rfs_ed_avg #(
      .DONE_CYC (ED_DONE_CYC)
   ) u_ed (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .meas      (meas)
   );

   // value held until the next measurement completes
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ed_r <= `RFS_REG_RST;
      end else if (meas.done) begin
         ed_r <= meas.result;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   logic [15:0] since_r;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         since_r <= 16'hFFFF;
      end else if (meas.start) begin
         since_r <= 16'h0000;
      end else if (since_r != 16'hFFFF) begin
         since_r <= since_r + 16'h0001;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_short_frame: assert property (
      rx_frame_end_i && !auto_retry_transmit_i && !auto_ack_receive_i &&
      rx_len_i < `RFS_MIN_FCS_LEN |=> frame_done_irq_o && !ok_r)
      else $error("short frame not flagged invalid");

   a_flag_hold: assert property (
      $changed(ok_r) |-> frame_done_irq_o)
      else $error("checksum flag moved without frame done");

   a_aack_drop: assert property (
      rx_frame_end_i && auto_ack_receive_i && !auto_retry_transmit_i &&
      !chk_ok |=> frame_discard_o && !frame_done_irq_o ##1
      ok_r == $past(ok_r, 2))
      else $error("bad frame not discarded");

   a_ack_refuse: assert property (
      rx_frame_end_i && auto_retry_transmit_i |=>
      (ack_accept_o != ack_reject_o) && ack_reject_o == !$past(chk_ok) &&
      !frame_done_irq_o)
      else $error("ack checksum decision wrong");

   a_txctl_write: assert property (
      wr_txctl |=> tx_auto_fcs_o == $past(hwdata_i[7]) &&
      tx_power_setting_o == $past(hwdata_i[3:0]))
      else $error("control write lost");

   a_ed_outside: assert property (
      take && !hwrite_i && a_idx == `RFS_IDX_ED && !rx_state_i |=>
      hrdata_o == 32'h00000000)
      else $error("energy read not zero outside receive");

   a_ed_range: assert property (
      ed_r <= `RFS_ED_MAX)
      else $error("energy value out of range");

   a_ed_latency: assert property (
      meas.done |-> since_r == ED_M1 ##1 ed_r == $past(meas.result))
      else $error("energy result at wrong time");

   a_sfd_masked: assert property (
      ext_mode_i |=> !frame_start_irq_o)
      else $error("frame start raised in extended mode");

   a_rssi_range: assert property (
      (rssi_r <= `RFS_RSSI_MAX) and (!rx_state_i |=> rssi_r == 5'h00))
      else $error("signal strength out of range");

   a_rssi_rate: assert property (
      $changed(rssi_r) && $past(rx_state_i) |-> $past(rssi_stb))
      else $error("signal strength changed off its period");

   a_ctl_reserved: assert property (
      take && !hwrite_i && a_idx == `RFS_IDX_TXCTL |=>
      hrdata_o[31:8] == 24'h000000 && hrdata_o[6:4] == 3'h0)
      else $error("control reserved bits not zero");

   a_stat_layout: assert property (
      take && !hwrite_i && a_idx == `RFS_IDX_RXSTAT |=>
      hrdata_o[31:8] == 24'h000000 && hrdata_o[6:5] == 2'h0 &&
      hrdata_o[7] == $past(ok_r))
      else $error("status read layout wrong");

   a_ack_no_flag: assert property (
      rx_frame_end_i && auto_retry_transmit_i |=> $stable(ok_r))
      else $error("acknowledgement moved the checksum flag");

   a_manual_start: assert property (
      wr_ed && rx_state_i |=> meas.busy && since_r == 16'h0000)
      else $error("energy write did not start a run");

   a_sfd_start: assert property (
      sfd_detect_i && rx_state_i |=> meas.busy && since_r == 16'h0000)
      else $error("delimiter did not start a run");

   a_done_idle: assert property (
      meas.done |-> !meas.busy)
      else $error("energy run still busy at completion");

   a_ed_hold: assert property (
      $changed(ed_r) |-> $past(meas.done))
      else $error("energy value moved without a finished run");

   a_ed_read: assert property (
      take && !hwrite_i && a_idx == `RFS_IDX_ED && rx_state_i |=>
      hrdata_o == {24'h000000, $past(ed_r)})
      else $error("energy read does not return the result");

   a_start_irq: assert property (
      sfd_detect_i && rx_state_i && !ext_mode_i |=> frame_start_irq_o)
      else $error("frame start not raised in basic mode");

   a_rssi_take: assert property (
      rssi_stb && rssi_level_i <= `RFS_RSSI_MAX |=>
      rssi_r == $past(rssi_level_i))
      else $error("signal strength sample not taken");

   c_frame_done:  cover property (frame_done_irq_o && ok_r);
   c_discard:     cover property (frame_discard_o);
   c_ack_ok:      cover property (ack_accept_o);
   c_ed_done:     cover property (meas.done ##1 ed_r != 8'h00);
   c_ack_bad:     cover property (ack_reject_o);
endmodule
`default_nettype wire

// ### bench/rfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rfs_host_model (
   input  wire logic        sys_clk_i,
   input  wire logic        hready_i,
   input  wire logic [31:0] hrdata_i,
   output logic             hsel_o,
   output logic [31:0]      haddr_o,
   output logic [1:0]       htrans_o,
   output logic             hwrite_o,
   output logic [2:0]       hsize_o,
   output logic [31:0]      hwdata_o
);
   initial begin
      hsel_o = 1'b0;
      haddr_o = 32'h0;
      htrans_o = 2'h0;
      hwrite_o = 1'b0;
      hsize_o = 3'h2;
      hwdata_o = 32'h0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one single word transfer; the design decides when energy runs start,
   // so it keeps them to receive states, in basic and in extended mode
   task automatic xfer(input logic [31:0] addr, input logic wr,
                       input logic [31:0] wdata, output logic [31:0] rdata);
      @(posedge sys_clk_i);
      hsel_o <= 1'b1;
      haddr_o <= addr;
      htrans_o <= 2'h2;
      hwrite_o <= wr;
      hsize_o <= 3'h2;
      do @(posedge sys_clk_i); while (hready_i !== 1'b1);
      htrans_o <= 2'h0;
      // reads put a changing pattern on the idle write lanes
      hwdata_o <= wr ? wdata : ~hwdata_o;
      do @(posedge sys_clk_i); while (hready_i !== 1'b1);
      rdata = hrdata_i;
   endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rfs_pkg::*;
   localparam int ED_CYC = 300;
   logic          sys_clk_i, rst_n_i, hsel, hwrite, hready, hresp;
   logic [31:0]   haddr, hwdata, hrdata;
   logic [1:0]    htrans;
   logic [2:0]    hsize;
   logic          rx_state, ext_mode, aa, ar, sfd, bvld, fend;
   rfs_byte_type  rx_byte;
   logic [6:0]    rx_len;
   rfs_rssi_type  rssi;
   logic          f_start, f_done, f_disc, a_acc, a_rej, auto_fcs;
   logic [3:0]    pwr;
   int            fails = 0, samples_checked = 0, cyc = 0;
   int            n_start = 0, n_done = 0, n_disc = 0, n_acc = 0, n_rej = 0;

   rfs_top #(.ED_DONE_CYC(ED_CYC), .RSSI_CYC(4)) u_dut (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
      .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
      .rx_state_i(rx_state), .ext_mode_i(ext_mode),
      .auto_ack_receive_i(aa), .auto_retry_transmit_i(ar),
      .sfd_detect_i(sfd), .rx_byte_vld_i(bvld), .rx_byte_i(rx_byte),
      .rx_frame_end_i(fend), .rx_len_i(rx_len), .rssi_level_i(rssi),
      .frame_start_irq_o(f_start), .frame_done_irq_o(f_done),
      .frame_discard_o(f_disc), .ack_accept_o(a_acc),
      .ack_reject_o(a_rej), .tx_auto_fcs_o(auto_fcs),
      .tx_power_setting_o(pwr));

   rfs_host_model u_host (
      .sys_clk_i(sys_clk_i), .hready_i(hready), .hrdata_i(hrdata),
      .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
      .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   // pulses are counted so that no check depends on the sampling moment
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      n_start <= n_start + (f_start === 1'b1);
      n_done <= n_done + (f_done === 1'b1);
      n_disc <= n_disc + (f_disc === 1'b1);
      n_acc <= n_acc + (a_acc === 1'b1);
      n_rej <= n_rej + (a_rej === 1'b1);
      if (cyc == 20000) begin
         fails++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      if (fails == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         fails++;
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] t;
      u_host.xfer(a, 1'b1, d, t);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] t;
      u_host.xfer(a, 1'b0, 32'h0, t);
      check(t, exp);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   // payload plus its two checksum octets, low octet first; bad flips one bit
   task automatic send_frame(input int n, input logic bad);
      logic [7:0]  b [0:15];
      logic [15:0] c;
      c = 16'h0000;
      // a one-octet frame is a lone zero with a clean residue
      b[0] = 8'h00;
      for (int i = 0; i < n - 2; i++) begin
         b[i] = 8'h41 + 8'(i);
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++)
            c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      end
      if (n >= 2) begin
         b[n-2] = c[7:0];
         b[n-1] = c[15:8] ^ {7'h00, bad};
      end
      @(posedge sys_clk_i);
      sfd <= 1'b1;
      @(posedge sys_clk_i);
      sfd <= 1'b0;
      for (int i = 0; i < n; i++) begin
         bvld <= 1'b1;
         rx_byte <= b[i];
         @(posedge sys_clk_i);
      end
      bvld <= 1'b0;
      @(posedge sys_clk_i);
      fend <= 1'b1;
      rx_len <= 7'(n);
      @(posedge sys_clk_i);
      fend <= 1'b0;
      wait_cyc(3);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic reg_tests;
      rd_chk(32'h14, 32'h00);
      rd_chk(32'h18, 32'h00);
      rd_chk(32'h1C, 32'h00);
      wr(32'h14, 32'hFF);
      check({31'h0, hresp}, 32'h0);
      rd_chk(32'h14, 32'h8F);
      check({27'h0, auto_fcs, pwr}, 32'h1F);
      wr(32'h14, 32'h03);
      @(posedge sys_clk_i);
      #1 check({27'h0, auto_fcs, pwr}, 32'h03);
      wr(32'h20, 32'hFF);
      rd_chk(32'h20, 32'h00);
      rd_chk(32'h1C, 32'h00);
   endtask

   // the first read falls just before the result lands, the later ones after a result
   task automatic ed_tests;
      rx_state <= 1'b1;
      rssi <= 5'h14;
      wait_cyc(8);
      wr(32'h1C, 32'hFF);
      wait_cyc(ED_CYC - 8);
      rd_chk(32'h1C, 32'h00);
      wait_cyc(10);
      rd_chk(32'h1C, 32'h3C);
      wait_cyc(100);
      rd_chk(32'h1C, 32'h3C);
      rssi <= 5'h1F;
      wait_cyc(8);
      rd_chk(32'h18, 32'h1C);
      wr(32'h1C, 32'h00);
      wait_cyc(ED_CYC + 5);
      rd_chk(32'h1C, 32'h54);
      rssi <= 5'h0A;
      wait_cyc(4);
      @(posedge sys_clk_i);
      sfd <= 1'b1;
      @(posedge sys_clk_i);
      sfd <= 1'b0;
      wait_cyc(ED_CYC + 5);
      rd_chk(32'h1C, 32'h1E);
      rx_state <= 1'b0;
      rd_chk(32'h1C, 32'h00);
      rd_chk(32'h18, 32'h00);
      rx_state <= 1'b1;
      rssi <= 5'h05;
   endtask

   task automatic frame_tests;
      int s0, d0;
      s0 = n_start;
      d0 = n_done;
      send_frame(5, 1'b0);
      check(n_done - d0, 1);
      check(n_start - s0, 1);
      rd_chk(32'h18, 32'h85);
      send_frame(1, 1'b0);
      check(n_done - d0, 2);
      rd_chk(32'h18, 32'h05);
      send_frame(5, 1'b1);
      rd_chk(32'h18, 32'h05);
      send_frame(2, 1'b0);
      rd_chk(32'h18, 32'h85);
      aa <= 1'b1;
      d0 = n_done;
      send_frame(6, 1'b1);
      check(n_done - d0, 0);
      check(n_disc, 1);
      rd_chk(32'h18, 32'h85);
      aa <= 1'b0;
      ar <= 1'b1;
      send_frame(5, 1'b0);
      send_frame(5, 1'b1);
      check({n_acc[15:0], n_rej[15:0]}, 32'h00010001);
      check(n_done - d0, 0);
      ar <= 1'b0;
      ext_mode <= 1'b1; // signal strength left unread here
      s0 = n_start;
      send_frame(5, 1'b0);
      check(n_start - s0, 0);
      check(n_done - d0, 1);
   endtask

   initial begin
      rst_n_i = 1'b0;
      {rx_state, ext_mode, aa, ar, sfd, bvld, fend} = 7'h00;
      rx_byte = 8'h00;
      rx_len = 7'h00;
      rssi = 5'h00;
      repeat (4) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      reg_tests();
      ed_tests();
      frame_tests();
      tally_and_finish();
   end
endmodule
`default_nettype wire
